// File: logic/ich_pkg.sv
// Package: constants and types for the input channel handshake
`default_nettype none
package ich_pkg;
  localparam int unsigned DATA_W       = 12;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Latest drop of input ready after request ends
  localparam int unsigned READY_DROP_NS = 4000;
  localparam int unsigned READY_DROP_CYC =
    (READY_DROP_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (READY_DROP_NS / CLK_PERIOD_NS);
  // Default storage area size in words
  localparam int unsigned AREA_WORDS   = 64;
  localparam logic [11:0] DATA_ZERO    = 12'h000;

  // Computer end states
  typedef enum logic [3:0] {
    ICH_C_IDLE = 4'b0001,
    ICH_C_REQ  = 4'b0010,
    ICH_C_WAIT = 4'b0100,
    ICH_C_DONE = 4'b1000
  } ich_cpu_state_t;

  // Equipment end states
  typedef enum logic [3:0] {
    ICH_E_IDLE = 4'b0001,
    ICH_E_RDY  = 4'b0010,
    ICH_E_DISC = 4'b0100,
    ICH_E_HOLD = 4'b1000
  } ich_eq_state_t;
endpackage
`default_nettype wire

// File: logic/ich_link_if.sv
// Interface: input cable between computer and equipment
`timescale 1ns/1ns
`default_nettype none
interface ich_link_if;
  logic        input_request;
  logic        input_ready;
  logic        disconnect;
  logic [11:0] input_data;

  modport computer (
    output input_request,
    input  input_ready,
    input  disconnect,
    input  input_data
  );
  modport equipment (
    input  input_request,
    output input_ready,
    output disconnect,
    output input_data
  );
endinterface
`default_nettype wire

// File: logic/ich_computer.sv
// Computer end of the input channel handshake
//
// Contract
// - Hold request while ready for a word
// - Drop request on input ready
// - Equipment raises ready only with word present
// - Equipment drops ready after request drops
// - Equipment signals disconnect after final word
// - On disconnect drop request, end transfer
// - Equipment releases disconnect after request drops
// - Equipment drives input register onto lines
// - Equipment withdraws word when request drops
// - Status response uses same input lines
// - Storage area larger than expected block
// - Ready removed within 4 us
// - Mode chosen beforehand by function code
`timescale 1ns/1ns
`default_nettype none
module ich_computer #(
  parameter int unsigned AREA_WORDS = ich_pkg::AREA_WORDS
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  ich_link_if.computer                    link,
  input  wire logic                       start,
  input  wire logic [15:0]                area_words,
  output logic                            word_valid,
  output logic [ich_pkg::DATA_W-1:0]      word_data,
  output logic                            busy,
  output logic                            done,
  output logic                            done_by_disconnect,
  output logic [15:0]                     word_count
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0]                 rdy_sync_q;
  logic [1:0]                 disc_sync_q;
  // Data shares the ready delay so both stay aligned
  logic [ich_pkg::DATA_W-1:0] dat_s1_q;
  logic [ich_pkg::DATA_W-1:0] dat_s2_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdy_sync_q  <= 2'h0;
      disc_sync_q <= 2'h0;
      dat_s1_q    <= ich_pkg::DATA_ZERO;
      dat_s2_q    <= ich_pkg::DATA_ZERO;
    end else begin
      rdy_sync_q  <= {rdy_sync_q[0], link.input_ready};
      disc_sync_q <= {disc_sync_q[0], link.disconnect};
      dat_s1_q    <= link.input_data;
      dat_s2_q    <= dat_s1_q;
    end
  end

  logic rdy_s;
  logic disc_s;
  assign rdy_s  = rdy_sync_q[1];
  assign disc_s = disc_sync_q[1];

  // ****************************************
  // Handshake state machine
  // ****************************************
  ich_pkg::ich_cpu_state_t    state_q, state_d;
  logic                       req_q, req_d;
  logic                       done_q, done_d;
  logic                       dby_q, dby_d;
  logic [15:0]                lim_q, lim_d;
  logic                       vld_q, vld_d;
  logic [ich_pkg::DATA_W-1:0] data_q, data_d;
  logic [15:0]                cnt_q, cnt_d;
  logic                       lines_idle;
  logic                       block_start;
  logic                       word_take;

  // Both answer lines low: previous handshake over
  assign lines_idle  = !rdy_s && !disc_s;
  assign block_start = (state_q == ich_pkg::ICH_C_IDLE) && start;
  // Disconnect wins over ready seen in the same cycle
  assign word_take   = (state_q == ich_pkg::ICH_C_REQ) && rdy_s && !disc_s;

  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    done_d  = 1'b0;
    dby_d   = dby_q;
    lim_d   = lim_q;
    case (state_q)
      ich_pkg::ICH_C_IDLE: begin
        if (block_start) begin
          // Zero selects the default area size
          lim_d   = (area_words == 16'h0000) ?
                    AREA_WORDS[15:0] : area_words;
          dby_d   = 1'b0;
          state_d = ich_pkg::ICH_C_WAIT;
        end
      end
      ich_pkg::ICH_C_REQ: begin
        if (disc_s) begin
          req_d   = 1'b0;
          dby_d   = 1'b1;
          state_d = ich_pkg::ICH_C_DONE;
        end else if (word_take) begin
          req_d   = 1'b0;
          state_d = ich_pkg::ICH_C_WAIT;
        end
      end
      ich_pkg::ICH_C_WAIT: begin
        if (lines_idle) begin
          if (cnt_q >= lim_q) begin
            state_d = ich_pkg::ICH_C_DONE;
          end else begin
            req_d   = 1'b1;
            state_d = ich_pkg::ICH_C_REQ;
          end
        end
      end
      ich_pkg::ICH_C_DONE: begin
        // One-cycle done pulse, then idle
        done_d  = 1'b1;
        state_d = ich_pkg::ICH_C_IDLE;
      end
      default: begin
        state_d = ich_pkg::ICH_C_IDLE;
        req_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ich_pkg::ICH_C_IDLE;
      req_q   <= 1'b0;
      done_q  <= 1'b0;
      dby_q   <= 1'b0;
      lim_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      done_q  <= done_d;
      dby_q   <= dby_d;
      lim_q   <= lim_d;
    end
  end

  // ****************************************
  // Word capture
  // ****************************************
  always_comb begin
    vld_d  = 1'b0;
    data_d = data_q;
    cnt_d  = cnt_q;
    // Count restarts with each block
    if (block_start) begin
      cnt_d = 16'h0000;
    end else if (word_take) begin
      vld_d  = 1'b1;
      data_d = dat_s2_q;
      cnt_d  = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vld_q  <= 1'b0;
      data_q <= ich_pkg::DATA_ZERO;
      cnt_q  <= 16'h0000;
    end else begin
      vld_q  <= vld_d;
      data_q <= data_d;
      cnt_q  <= cnt_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic busy_q;
  logic busy_d;

  // Busy from the next state, so it rises with start
  always_comb begin
    busy_d = (state_d != ich_pkg::ICH_C_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign link.input_request = req_q;
  assign word_valid         = vld_q;
  assign word_data          = data_q;
  assign busy               = busy_q;
  assign done               = done_q;
  assign done_by_disconnect = dby_q;
  assign word_count         = cnt_q;
endmodule // ich_computer
`default_nettype wire

// File: logic/ich_equipment.sv
// Equipment end of the input channel handshake
`timescale 1ns/1ns
`default_nettype none
module ich_equipment (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  ich_link_if.equipment                   link,
  input  wire logic                       sel_input,
  input  wire logic                       sel_status,
  input  wire logic [ich_pkg::DATA_W-1:0] status_word,
  input  wire logic                       src_valid,
  input  wire logic [ich_pkg::DATA_W-1:0] src_data,
  input  wire logic                       src_last,
  output logic                            src_ready,
  output logic                            disc_sent
);
  // ****************************************
  // Request synchroniser
  // ****************************************
  logic [1:0] req_sync_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req_sync_q <= 2'h0;
    end else begin
      req_sync_q <= {req_sync_q[0], link.input_request};
    end
  end
  logic req_s;
  assign req_s = req_sync_q[1];

  // ****************************************
  // Handshake state machine
  // ****************************************
  ich_pkg::ich_eq_state_t     state_q, state_d;
  logic                       rdy_q, rdy_d;
  logic                       disc_q, disc_d;
  logic [ich_pkg::DATA_W-1:0] dat_q, dat_d;
  logic                       last_q, last_d;
  logic                       take_q, take_d;
  logic                       dsent_q, dsent_d;

  always_comb begin
    state_d = state_q;
    rdy_d   = rdy_q;
    disc_d  = disc_q;
    dat_d   = dat_q;
    last_d  = last_q;
    take_d  = 1'b0;
    dsent_d = 1'b0;
    case (state_q)
      ich_pkg::ICH_E_IDLE: begin
        // Act only when a mode is selected
        if (req_s && sel_status) begin
          dat_d   = status_word;
          rdy_d   = 1'b1;
          state_d = ich_pkg::ICH_E_RDY;
        end else if (req_s && sel_input && last_q) begin
          disc_d  = 1'b1;
          dsent_d = 1'b1;
          state_d = ich_pkg::ICH_E_DISC;
        end else if (req_s && sel_input && src_valid) begin
          dat_d   = src_data;
          last_d  = src_last;
          take_d  = 1'b1;
          rdy_d   = 1'b1;
          state_d = ich_pkg::ICH_E_RDY;
        end
      end
      ich_pkg::ICH_E_RDY: begin
        if (!req_s) begin
          rdy_d   = 1'b0;
          dat_d   = ich_pkg::DATA_ZERO;
          state_d = ich_pkg::ICH_E_IDLE;
        end
      end
      ich_pkg::ICH_E_DISC: begin
        if (!req_s) begin
          disc_d  = 1'b0;
          last_d  = 1'b0;
          state_d = ich_pkg::ICH_E_IDLE;
        end
      end
      default: begin
        state_d = ich_pkg::ICH_E_IDLE;
        rdy_d   = 1'b0;
        disc_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ich_pkg::ICH_E_IDLE;
      rdy_q   <= 1'b0;
      disc_q  <= 1'b0;
      dat_q   <= ich_pkg::DATA_ZERO;
      last_q  <= 1'b0;
      take_q  <= 1'b0;
      dsent_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdy_q   <= rdy_d;
      disc_q  <= disc_d;
      dat_q   <= dat_d;
      last_q  <= last_d;
      take_q  <= take_d;
      dsent_q <= dsent_d;
    end
  end

  assign link.input_ready = rdy_q;
  assign link.disconnect  = disc_q;
  assign link.input_data  = dat_q;
  assign src_ready        = take_q;
  assign disc_sent        = dsent_q;
endmodule // ich_equipment
`default_nettype wire

// File: tb/ich_link_props.sv
// Checker: handshake properties on the input cable
`timescale 1ns/1ns
`default_nettype none
module ich_link_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        input_request,
  input wire logic        input_ready,
  input wire logic        disconnect,
  input wire logic [11:0] input_data
);
  // ******************
  // Link properties
  // ******************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  req_hold_a: assert property (
    $fell(input_request) |-> $past(input_ready) || $past(disconnect))
    else $error("request dropped unanswered");
  req_drop_a: assert property (
    $rose(input_ready) |-> ##3 !input_request)
    else $error("request not dropped on ready");
  rdy_cause_a: assert property (
    $rose(input_ready) |-> input_request && !disconnect)
    else $error("ready without request");
  rdy_stand_a: assert property (
    input_ready && input_request |=> input_ready)
    else $error("ready dropped early");
  line_drop_a: assert property (
    $fell(input_request) |-> ##3 !input_ready && !disconnect)
    else $error("ready or disconnect held too long");
  disc_cause_a: assert property (
    $rose(disconnect) |-> input_request && !input_ready)
    else $error("disconnect without request");
  disc_end_a: assert property (
    $rose(disconnect) |-> ##3 !input_request)
    else $error("request held after disconnect");
  data_off_a: assert property (
    !input_ready |-> input_data == 12'h000)
    else $error("data left on lines");
  data_hold_a: assert property (
    input_ready && $past(input_ready) |-> $stable(input_data))
    else $error("data moved while ready");
endmodule // ich_link_props
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: computer and equipment ends joined by the cable
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ******************
  // Bench
  // ******************
  logic        clk_sys;
  logic        reset;
  logic        start;
  logic [15:0] area_words;
  logic        word_valid;
  logic        busy;
  logic        done;
  logic        done_by_disconnect;
  logic [11:0] word_data;
  logic [15:0] word_count;
  logic        sel_input;
  logic        sel_status;
  logic [11:0] status_word;
  logic        src_valid;
  logic [11:0] src_data;
  logic        src_last;
  logic        src_ready;
  logic        disc_sent;
  logic [11:0] idx;
  logic [11:0] n_src;
  logic [11:0] last_idx;
  logic        exp_stat;
  int          errors;
  int          num_checks;

  ich_link_if link ();
  ich_computer i_ich_computer (.clk_sys(clk_sys), .reset(reset),
    .link(link.computer), .start(start), .area_words(area_words),
    .word_valid(word_valid), .word_data(word_data), .busy(busy),
    .done(done), .done_by_disconnect(done_by_disconnect),
    .word_count(word_count));
  ich_equipment i_ich_equipment (.clk_sys(clk_sys), .reset(reset),
    .link(link.equipment), .sel_input(sel_input), .sel_status(sel_status),
    .status_word(status_word), .src_valid(src_valid), .src_data(src_data),
    .src_last(src_last), .src_ready(src_ready), .disc_sent(disc_sent));
  ich_link_props i_ich_link_props (.clk_sys(clk_sys), .reset(reset),
    .input_request(link.input_request), .input_ready(link.input_ready),
    .disconnect(link.disconnect), .input_data(link.input_data));

  // Word source: restarts between blocks, advances on each taken word
  assign src_valid = idx < n_src;
  assign src_data  = 12'h100 + idx;
  assign src_last  = idx == last_idx;
  always @(negedge clk_sys) begin
    if (busy !== 1'b1) begin
      idx <= 12'h000;
    end else if (src_ready === 1'b1) begin
      idx <= idx + 12'h001;
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever begin
      #4 clk_sys = ~clk_sys;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic run_block(input logic [15:0] area, input logic [15:0] n_exp,
                           input logic disc_exp);
    logic [15:0] got;
    logic [15:0] exp;
    logic [15:0] n_disc;
    got = 16'h0000;
    n_disc = 16'h0000;
    area_words = area;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    check({15'h0000, busy}, 16'h0001);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(negedge clk_sys);
      if (word_valid === 1'b1) begin
        exp = exp_stat ? {4'h0, status_word} : 16'h0100 + got;
        check({4'h0, word_data}, exp);
        got++;
      end
      if (disc_sent === 1'b1) begin
        n_disc++;
      end
    end
    check({15'h0000, done}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
    check(got, n_exp);
    check(word_count, n_exp);
    check(n_disc, {15'h0000, disc_exp});
    check({15'h0000, done_by_disconnect}, {15'h0000, disc_exp});
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic t_disconnect();
    n_src = 12'h003;
    last_idx = 12'h002;
    run_block(16'h0000, 16'h0003, 1'b1);
  endtask

  task automatic t_area();
    n_src = 12'h00a;
    last_idx = 12'hfff;
    run_block(16'h0002, 16'h0002, 1'b0);
  endtask

  task automatic t_status();
    n_src = 12'h000;
    sel_status = 1'b1;
    status_word = 12'h5a3;
    exp_stat = 1'b1;
    run_block(16'h0001, 16'h0001, 1'b0);
    sel_status = 1'b0;
    exp_stat = 1'b0;
  endtask

  // No mode selected: request stands unanswered until input mode is set
  task automatic t_no_mode();
    logic [15:0] got;
    logic        seen_word;
    got = 16'h0000;
    seen_word = 1'b0;
    sel_input = 1'b0;
    n_src = 12'h003;
    last_idx = 12'hfff;
    area_words = 16'h0001;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (40) begin
      @(negedge clk_sys);
      if (word_valid === 1'b1) begin
        seen_word = 1'b1;
      end
    end
    check({15'h0000, seen_word}, 16'h0000);
    check({15'h0000, link.input_ready}, 16'h0000);
    check({15'h0000, link.input_request}, 16'h0001);
    sel_input = 1'b1;
    for (int i = 0; i < 200 && done !== 1'b1; i++) begin
      @(negedge clk_sys);
      if (word_valid === 1'b1) begin
        check({4'h0, word_data}, 16'h0100);
        got++;
      end
    end
    check(got, 16'h0001);
    check({15'h0000, done}, 16'h0001);
    repeat (10) @(negedge clk_sys);
  endtask

  initial begin
    errors = 0;
    num_checks = 0;
    reset = 1'b1;
    start = 1'b0;
    area_words = 16'h0000;
    sel_input = 1'b1;
    sel_status = 1'b0;
    status_word = 12'h000;
    n_src = 12'h000;
    last_idx = 12'hfff;
    exp_stat = 1'b0;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    t_disconnect();
    t_area();
    t_status();
    t_no_mode();
    test_done();
  end

  // Watchdog
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
